// *** cio_regs.vh ***
// constants for the configurable io port block
`ifndef CIO_REGS_VH
`define CIO_REGS_VH
// ----------------------------------------------------------------
// port indices
// ----------------------------------------------------------------
`define CIO_PORT_C      3'h0
`define CIO_PORT_F      3'h1
`define CIO_PORT_G      3'h2
`define CIO_PORT_J      3'h3
`define CIO_PORT_L      3'h4
// ----------------------------------------------------------------
// register select within a port
// ----------------------------------------------------------------
`define CIO_SEL_CFG     2'h0
`define CIO_SEL_DATA    2'h1
`define CIO_SEL_PIN     2'h2
// ----------------------------------------------------------------
// port g special bit positions
// ----------------------------------------------------------------
`define CIO_G_EXTERNAL_INTERRUPT_PIN      0
`define CIO_G_WDOG      1
`define CIO_G_TCAP      2
`define CIO_G_TIO       3
`define CIO_G_SO        4
`define CIO_G_SK        5
`define CIO_G_SI        6
`define CIO_G_OSC       7
// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define CIO_RST_CFG     8'h00
`define CIO_RST_DATA    8'h00
`define CIO_RST_J_CFG   8'hff
`define CIO_RST_J_DATA  8'hff
`endif

// *** cio_bit_sync.v ***
// three-stage input synchroniser with agreement filter
`timescale 1ns/1ps
`default_nettype none
module cio_bit_sync #(
  parameter WIDTH = 8
) (
  // clock and reset
  input  wire             clock,
  input  wire             resetn,
  // raw and filtered levels
  input  wire [WIDTH-1:0] async_in,
  output reg  [WIDTH-1:0] level_q
);
  reg [WIDTH-1:0] s1_q;
  reg [WIDTH-1:0] s2_q;
  reg [WIDTH-1:0] s3_q;
  // s1 only feeds s2; level changes once s2 and s3 agree
  always @(posedge clock) begin
    if (!resetn) begin
      s1_q    <= {WIDTH{1'b0}};
      s2_q    <= {WIDTH{1'b0}};
      s3_q    <= {WIDTH{1'b0}};
      level_q <= {WIDTH{1'b0}};
    end else begin
      s1_q    <= async_in;
      s2_q    <= s1_q;
      s3_q    <= s2_q;
      level_q <= (s2_q & s3_q) | (level_q & (s2_q | s3_q));
    end
  end
endmodule // cio_bit_sync
`default_nettype wire

// *** cio_ports.v ***
// five 8-bit configurable io ports with port g special functions
`timescale 1ns/1ps
`default_nettype none
`include "cio_regs.vh"
module cio_ports #(
  parameter NPORT = 5
) (
  // clock and reset
  input  wire        clock,
  input  wire        resetn,
  // register access from the core
  input  wire [2:0]  reg_port,
  input  wire [1:0]  reg_sel,
  input  wire        reg_wr,
  input  wire [7:0]  reg_wdata,
  output reg  [7:0]  reg_rdata_q,
  // option and mode inputs
  input  wire        opt_watchdog_en,
  input  wire        opt_crystal,
  input  wire        opt_low_voltage,
  input  wire        bus_enable,
  // alternate function sources
  input  wire        watchdog_out,
  input  wire        osc_clock_out,
  input  wire        serial_out,
  input  wire        serial_out_en,
  input  wire        serial_shift_clock_out,
  input  wire        serial_shift_clock_oe,
  input  wire        timer_io_out,
  input  wire        timer_io_oe,
  input  wire        sda_drive_low,
  input  wire        scl_drive_low,
  // pins: c, f, g, j, l packed 8 bits each
  input  wire [39:0] pin_in,
  output reg  [39:0] pin_out_q,
  output reg  [39:0] pin_oe_q,
  output reg  [39:0] pin_pullup_q,
  // alternate function sinks
  output reg  [7:0]  portc_wake_in_q,
  output reg  [7:0]  portl_wake_in_q,
  output reg         serial_in_q,
  output reg         serial_shift_clock_in_q,
  output reg         timer_io_pin_q,
  output reg         timer_capture_pin_q,
  output reg         external_interrupt_pin_q,
  output reg         sda_in_q,
  output reg         scl_in_q,
  output reg         low_voltage_input_select_q,
  output reg         alt_shift_phase_q,
  output reg         halt_restart_delay_enable_q,
  output reg         halt_req_q,
  output reg         idle_req_q,
  output reg         halt_release_q
);
  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  wire [8*NPORT-1:0] cfg_all;
  wire [8*NPORT-1:0] data_all;
  wire [39:0] pin_lvl;
  reg         g7_prev_q;
  reg  [39:0] oe_d;
  reg  [39:0] out_d;
  reg  [39:0] pu_d;
  reg  [7:0]  rd_d;
  wire [7:0]  g_lvl;
  genvar      gi;

  // pin levels go through the three-flop filter
  cio_bit_sync #(.WIDTH(40)) u_sync (
    .clock    (clock),
    .resetn   (resetn),
    .async_in (pin_in),
    .level_q  (pin_lvl)
  );
  assign g_lvl = pin_lvl[8*`CIO_PORT_G +: 8];

  // ----------------------------------------------------------------
  // config and data registers per port
  // ----------------------------------------------------------------
  generate
    for (gi = 0; gi < NPORT; gi = gi + 1) begin : g_port
      reg [7:0] cfg_q;
      reg [7:0] data_q;
      // port j resets to driven high, all others hi-z
      always @(posedge clock) begin
        if (!resetn) begin
          cfg_q  <= (gi == `CIO_PORT_J) ? `CIO_RST_J_CFG  : `CIO_RST_CFG;
          data_q <= (gi == `CIO_PORT_J) ? `CIO_RST_J_DATA : `CIO_RST_DATA;
        end else if (reg_wr && reg_port == gi) begin
          if (reg_sel == `CIO_SEL_CFG)
            cfg_q <= reg_wdata;
          if (reg_sel == `CIO_SEL_DATA)
            data_q <= reg_wdata;
        end
      end
      // each port owns its flops, so every register has a single driver
      assign cfg_all[8*gi +: 8]  = cfg_q;
      assign data_all[8*gi +: 8] = data_q;
    end
  endgenerate

  // ----------------------------------------------------------------
  // pad control decode
  // ----------------------------------------------------------------
  // generic decode first, then port g and port l overrides
  integer i;
  always @* begin
    oe_d  = 40'h0;
    out_d = 40'h0;
    pu_d  = 40'h0;
    for (i = 0; i < 40; i = i + 1) begin
      oe_d[i]  = cfg_all[i];
      out_d[i] = cfg_all[i] & data_all[i];
      pu_d[i]  = ~cfg_all[i] & data_all[i];
    end
    // serial output and shift clock, timer io take the pin when active
    if (serial_out_en) begin
      oe_d[8*`CIO_PORT_G+`CIO_G_SO]  = 1'b1;
      out_d[8*`CIO_PORT_G+`CIO_G_SO] = serial_out;
    end
    if (serial_shift_clock_oe) begin
      oe_d[8*`CIO_PORT_G+`CIO_G_SK]  = 1'b1;
      out_d[8*`CIO_PORT_G+`CIO_G_SK] = serial_shift_clock_out;
    end
    if (timer_io_oe) begin
      oe_d[8*`CIO_PORT_G+`CIO_G_TIO]  = 1'b1;
      out_d[8*`CIO_PORT_G+`CIO_G_TIO] = timer_io_out;
    end
    // watchdog owns g1; pull-up high, drives only its low level
    if (opt_watchdog_en) begin
      oe_d[8*`CIO_PORT_G+`CIO_G_WDOG]  = ~watchdog_out;
      out_d[8*`CIO_PORT_G+`CIO_G_WDOG] = 1'b0;
      pu_d[8*`CIO_PORT_G+`CIO_G_WDOG]  = 1'b1;
    end
    // g6 never drives; its bits are mode controls
    oe_d[8*`CIO_PORT_G+`CIO_G_SI]  = 1'b0;
    out_d[8*`CIO_PORT_G+`CIO_G_SI] = 1'b0;
    pu_d[8*`CIO_PORT_G+`CIO_G_SI]  = 1'b0;
    // g7 is oscillator output with a crystal, else hi-z input
    oe_d[8*`CIO_PORT_G+`CIO_G_OSC]  = opt_crystal;
    out_d[8*`CIO_PORT_G+`CIO_G_OSC] = opt_crystal & osc_clock_out;
    pu_d[8*`CIO_PORT_G+`CIO_G_OSC]  = 1'b0;
    // open-drain bus lines on l0/l1 while the bus is enabled
    if (bus_enable) begin
      oe_d[8*`CIO_PORT_L+0]  = sda_drive_low;
      out_d[8*`CIO_PORT_L+0] = 1'b0;
      pu_d[8*`CIO_PORT_L+0]  = 1'b0;
      oe_d[8*`CIO_PORT_L+1]  = scl_drive_low;
      out_d[8*`CIO_PORT_L+1] = 1'b0;
      pu_d[8*`CIO_PORT_L+1]  = 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // read mux
  // ----------------------------------------------------------------
  // unused port numbers and selects read zero
  always @* begin
    rd_d = 8'h00;
    if (reg_port < NPORT) begin
      case (reg_sel)
        `CIO_SEL_CFG:  rd_d = cfg_all[8*reg_port +: 8];
        `CIO_SEL_DATA: rd_d = data_all[8*reg_port +: 8];
        `CIO_SEL_PIN:  rd_d = pin_lvl[8*reg_port +: 8];
        default:       rd_d = 8'h00;
      endcase
      if (reg_port == `CIO_PORT_G && reg_sel == `CIO_SEL_DATA)
        rd_d = {2'b00, data_all[8*`CIO_PORT_G +: 6]};
    end
  end

  // ----------------------------------------------------------------
  // registered outputs
  // ----------------------------------------------------------------
  // everything leaves via a flop; adds one cycle of latency to pads
  always @(posedge clock) begin
    if (!resetn) begin
      reg_rdata_q                 <= 8'h00;
      pin_oe_q                    <= {8'h00, `CIO_RST_J_CFG, 24'h0};
      pin_out_q                   <= {8'h00, `CIO_RST_J_DATA, 24'h0};
      pin_pullup_q                <= 40'h0;
      portc_wake_in_q             <= 8'h00;
      portl_wake_in_q             <= 8'h00;
      serial_in_q                 <= 1'b0;
      serial_shift_clock_in_q     <= 1'b0;
      timer_io_pin_q              <= 1'b0;
      timer_capture_pin_q         <= 1'b0;
      external_interrupt_pin_q    <= 1'b0;
      sda_in_q                    <= 1'b0;
      scl_in_q                    <= 1'b0;
      low_voltage_input_select_q  <= 1'b0;
      alt_shift_phase_q           <= 1'b0;
      halt_restart_delay_enable_q <= 1'b0;
      halt_req_q                  <= 1'b0;
      idle_req_q                  <= 1'b0;
      halt_release_q              <= 1'b0;
      g7_prev_q                   <= 1'b1; // a pin idling high still gives one rise, as the filtered g7 level resets low
    end else begin
      reg_rdata_q  <= rd_d;
      pin_oe_q     <= oe_d;
      pin_out_q    <= out_d;
      pin_pullup_q <= pu_d;
      // port c wake-up gating belongs to software via its enable
      portc_wake_in_q <= pin_lvl[8*`CIO_PORT_C +: 8];
      portl_wake_in_q <= pin_lvl[8*`CIO_PORT_L +: 8];
      sda_in_q        <= pin_lvl[8*`CIO_PORT_L+0];
      scl_in_q        <= pin_lvl[8*`CIO_PORT_L+1];
      // alternate inputs from port g
      serial_in_q              <= g_lvl[`CIO_G_SI];
      serial_shift_clock_in_q  <= g_lvl[`CIO_G_SK];
      timer_io_pin_q           <= g_lvl[`CIO_G_TIO];
      timer_capture_pin_q      <= g_lvl[`CIO_G_TCAP];
      external_interrupt_pin_q <= g_lvl[`CIO_G_EXTERNAL_INTERRUPT_PIN];
      low_voltage_input_select_q <= opt_low_voltage & bus_enable;
      alt_shift_phase_q <= cfg_all[8*`CIO_PORT_G+`CIO_G_SI];
      halt_restart_delay_enable_q <= cfg_all[8*`CIO_PORT_G+`CIO_G_OSC] & ~opt_crystal;
      // one-cycle requests on a write of one
      halt_req_q <= reg_wr && reg_port == `CIO_PORT_G && reg_sel == `CIO_SEL_DATA && reg_wdata[`CIO_G_OSC];
      idle_req_q <= reg_wr && reg_port == `CIO_PORT_G && reg_sel == `CIO_SEL_DATA && reg_wdata[`CIO_G_SI];
      // rising g7 releases halt, only without the crystal
      g7_prev_q      <= g_lvl[`CIO_G_OSC];
      halt_release_q <= ~opt_crystal & g_lvl[`CIO_G_OSC] & ~g7_prev_q;
    end
  end
endmodule // cio_ports
`default_nettype wire

// *** cio_ports_sva.sv ***
// assertion checker for the configurable io ports
`timescale 1ns/1ps
`default_nettype none
module cio_ports_chk (
  // clock and reset
  input wire logic        clock,
  input wire logic        resetn,
  // register access
  input wire logic [2:0]  reg_port,
  input wire logic [1:0]  reg_sel,
  input wire logic        reg_wr,
  input wire logic [7:0]  reg_wdata,
  input wire logic [7:0]  reg_rdata_q,
  // options
  input wire logic        opt_crystal,
  input wire logic        opt_watchdog_en,
  input wire logic        watchdog_out,
  input wire logic        opt_low_voltage,
  input wire logic        bus_enable,
  // pads and status
  input wire logic [39:0] pin_oe_q,
  input wire logic [39:0] pin_out_q,
  input wire logic [39:0] pin_pullup_q,
  input wire logic        low_voltage_input_select_q,
  input wire logic        alt_shift_phase_q,
  input wire logic        halt_restart_delay_enable_q,
  input wire logic        halt_req_q,
  input wire logic        idle_req_q
);
  default clocking @(posedge clock); endclocking
  default disable iff (!resetn);
  // port g data and config write decodes
  wire g_dwr = reg_wr && reg_port == 3'h2 && reg_sel == 2'h1;
  wire g_cwr = reg_wr && reg_port == 3'h2 && reg_sel == 2'h0;
  a_g6_never_drives: assert property (!pin_oe_q[22]) else $error("g6 driven");
  a_halt_on_write: assert property (halt_req_q == $past(resetn && g_dwr && reg_wdata[7])) else $error("halt");
  a_idle_on_write: assert property (idle_req_q == $past(resetn && g_dwr && reg_wdata[6])) else $error("idle");
  a_g_top_zero: assert property (reg_port == 3'h2 && reg_sel == 2'h1 |=> reg_rdata_q[7:6] == 2'h0) else $error("g7 g6");
  a_shift_phase: assert property (g_cwr && reg_wdata[6] |-> ##[1:2] alt_shift_phase_q) else $error("phase");
  a_delay_rc_only: assert property (halt_restart_delay_enable_q |-> !$past(opt_crystal)) else $error("delay");
  a_low_volt_sel: assert property (
    low_voltage_input_select_q == $past(resetn && opt_low_voltage && bus_enable)) else $error("low voltage");
  a_g7_osc_drive: assert property (pin_oe_q[23] == $past(resetn && opt_crystal)) else $error("g7 drive");
  // the register bits of g1 must not leak through while the watchdog owns it
  a_wdog_owns_g1: assert property (
    $past(resetn && opt_watchdog_en) |-> pin_pullup_q[17] && pin_oe_q[17] == !$past(watchdog_out))
    else $error("g1 watchdog");
  // reset itself is the cause here, so this one stays armed during reset
  a_port_j_reset: assert property (disable iff (1'b0)
    !resetn |=> pin_oe_q[31:24] == 8'hff && pin_out_q[31:24] == 8'hff) else $error("port j reset");
endmodule // cio_ports_chk
bind cio_ports cio_ports_chk u_chk (.*);
`default_nettype wire

// *** cio_board.sv ***
// board model resolving the io pad levels
`timescale 1ns/1ps
`default_nettype none
module cio_board (
  // pads and board drivers
  input  wire logic        clock,
  input  wire logic [39:0] pin_out,
  input  wire logic [39:0] pin_oe,
  input  wire logic [39:0] pin_pullup,
  input  wire logic [39:0] ext_val,
  input  wire logic [39:0] ext_en,
  output wire logic [39:0] pin_level
);
  logic [39:0] float_q = 40'h0;
  // a floating pin wanders so no check can lean on a stale level
  always @(posedge clock) float_q <= ~float_q;
  // device drive wins, then the board, then the weak pull-up
  assign pin_level = (pin_oe & pin_out) | (~pin_oe & ext_en & ext_val) | (~pin_oe & ~ext_en & (pin_pullup | float_q));
endmodule // cio_board
`default_nettype wire

// *** test_cio_ports.sv ***
// self-checking testbench for the configurable io ports
`timescale 1ns/1ps
`default_nettype none
module test_cio_ports;
  logic clock = 1'b0, resetn = 1'b0, reg_wr = 1'b0, opt_watchdog_en = 1'b0, opt_crystal = 1'b0;
  logic opt_low_voltage = 1'b0, bus_enable = 1'b0, watchdog_out = 1'b1, osc_clock_out = 1'b0;
  logic serial_out = 1'b0, serial_out_en = 1'b0, serial_shift_clock_out = 1'b0, serial_shift_clock_oe = 1'b0;
  logic timer_io_out = 1'b0, timer_io_oe = 1'b0, sda_drive_low = 1'b0, scl_drive_low = 1'b0;
  logic [2:0]  reg_port = 3'h0;
  logic [1:0]  reg_sel = 2'h0;
  logic [7:0]  reg_wdata = 8'h00, reg_rdata_q, portc_wake_in_q, portl_wake_in_q;
  logic [39:0] ext_val = 40'h0, ext_en = 40'h0, pin_in, pin_out_q, pin_oe_q, pin_pullup_q;
  logic serial_in_q, serial_shift_clock_in_q, timer_io_pin_q, timer_capture_pin_q, external_interrupt_pin_q;
  logic sda_in_q, scl_in_q, low_voltage_input_select_q, alt_shift_phase_q, halt_restart_delay_enable_q;
  logic halt_req_q, idle_req_q, halt_release_q;
  logic [2:0]  pl [4] = '{3'h0, 3'h1, 3'h3, 3'h4};
  int err_count = 0;
  int cmp_count = 0;
  int n;
  always #5 clock = ~clock;
  cio_ports u_dut (.*);
  cio_board u_board (.clock, .pin_out(pin_out_q), .pin_oe(pin_oe_q), .pin_pullup(pin_pullup_q), .ext_val, .ext_en,
    .pin_level(pin_in));
  // ----------------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------------
  task automatic chk(input string what, input logic [39:0] exp, input logic [39:0] got);
    cmp_count++;
    if (got !== exp) begin
      err_count++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic cyc(input int k);
    repeat (k) @(negedge clock);
  endtask
  task automatic wr(input logic [2:0] p, input logic [1:0] s, input logic [7:0] d);
    @(negedge clock);
    {reg_port, reg_sel, reg_wdata, reg_wr} = {p, s, d, 1'b1};
    @(negedge clock);
    reg_wr = 1'b0;
  endtask
  // read data is registered, so it is looked at one edge later
  task automatic rd(input logic [2:0] p, input logic [1:0] s, input logic [7:0] e);
    @(negedge clock);
    {reg_port, reg_sel} = {p, s};
    @(negedge clock);
    chk("register read", e, reg_rdata_q);
  endtask
  task automatic give_verdict;
    $display("comparisons %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  // ----------------------------------------------------------------
  // tests
  // ----------------------------------------------------------------
  initial begin
    cyc(12);
    resetn = 1'b1;
    rd(3'h3, 2'h0, 8'hff);
    rd(3'h3, 2'h1, 8'hff);
    foreach (pl[i]) begin
      wr(pl[i], 2'h1, {5'h0, pl[i]} ^ 8'h5a);
      rd(pl[i], 2'h1, {5'h0, pl[i]} ^ 8'h5a);
    end
    // port f: hi-z, pull-up, drive low, drive high on bits 0..3
    {ext_en[15:8], ext_val[15:8]} = 16'hf1f0;
    wr(3'h1, 2'h0, 8'h0c);
    wr(3'h1, 2'h1, 8'h0a);
    cyc(2);
    chk("f oe", 8'h0c, pin_oe_q[15:8]);
    chk("f pullup", 8'h02, pin_pullup_q[15:8]);
    chk("f out", 8'h08, pin_out_q[15:8] & pin_oe_q[15:8]);
    cyc(6);
    rd(3'h1, 2'h2, 8'hfa);
    // port g trigger bits
    wr(3'h2, 2'h1, 8'hff);
    chk("halt idle", 2'h3, {halt_req_q, idle_req_q});
    rd(3'h2, 2'h1, 8'h3f);
    wr(3'h2, 2'h0, 8'hff);
    cyc(2);
    chk("g special", 4'h6, {pin_oe_q[22], alt_shift_phase_q, halt_restart_delay_enable_q, pin_oe_q[23]});
    opt_crystal = 1'b1;
    osc_clock_out = 1'b1;
    cyc(2);
    chk("g7 osc", 3'h6, {pin_oe_q[23], pin_out_q[23], halt_restart_delay_enable_q});
    opt_crystal = 1'b0;
    wr(3'h2, 2'h0, 8'h00);
    wr(3'h2, 2'h1, 8'h00);
    {ext_en[23:16], ext_val[23:16]} = 16'hff2d;
    cyc(6);
    ext_val[23] = 1'b1;
    n = 0;
    while (halt_release_q !== 1'b1 && n < 10) begin
      cyc(1);
      n++;
    end
    chk("halt release", 1'b1, halt_release_q);
    // watchdog owns g1 whatever its register bits say; set them to drive high
    wr(3'h2, 2'h0, 8'h02);
    wr(3'h2, 2'h1, 8'h02);
    {opt_watchdog_en, watchdog_out} = 2'h2;
    cyc(2);
    chk("g1 low", 3'h6, {pin_oe_q[17], pin_pullup_q[17], pin_out_q[17]});
    watchdog_out = 1'b1;
    cyc(2);
    chk("g1 free", 3'h2, {pin_oe_q[17], pin_pullup_q[17], pin_out_q[17]});
    opt_watchdog_en = 1'b0;
    // wake and alternate inputs; port c and port l wake levels pass through ungated
    {ext_en[7:0], ext_val[7:0], ext_en[39:32], ext_val[39:32]} = 32'hff3cffa5;
    cyc(6);
    chk("wake", 16'h3ca5, {portc_wake_in_q, portl_wake_in_q});
    chk("bus in", 2'h2, {sda_in_q, scl_in_q});
    chk("g alt", 5'h0f, {serial_in_q, serial_shift_clock_in_q, timer_io_pin_q, timer_capture_pin_q,
      external_interrupt_pin_q});
    {bus_enable, opt_low_voltage, sda_drive_low, timer_io_oe, timer_io_out} = 5'h1f;
    {serial_out_en, serial_out, serial_shift_clock_oe, serial_shift_clock_out, scl_drive_low} = 5'h1d;
    cyc(2);
    chk("bus out", 5'h1b, {low_voltage_input_select_q, pin_oe_q[32], pin_out_q[32], pin_oe_q[19], pin_out_q[19]});
    chk("serial out", 5'h1d, {pin_oe_q[20], pin_out_q[20], pin_oe_q[21], pin_out_q[21], pin_oe_q[33]});
    bus_enable = 1'b0;
    cyc(2);
    chk("low voltage", 1'b0, low_voltage_input_select_q);
    // second reset in mid-run
    resetn = 1'b0;
    cyc(2);
    resetn = 1'b1;
    rd(3'h3, 2'h1, 8'hff);
    rd(3'h2, 2'h0, 8'h00);
    give_verdict;
  end
  // cut a hang short well past the expected run
  initial begin
    #50us;
    err_count++;
    give_verdict;
  end
endmodule // test_cio_ports
`default_nettype wire
